// File: rtl/status_flags_pkg.sv
package status_flags_pkg;
	// register offset of the master status and reset register
	localparam logic [15:0] MASTER_STATUS_OFFSET = 16'h0001;
	localparam logic [15:0] MASTER_STATUS_RESET = 16'h0000;
	// field positions in the low flag bits
	localparam int BIT_BC_MSG_IN_PROGRESS = 9;
	localparam int BIT_BC_RUNNING = 8;
	localparam int BIT_MONITOR_MSG_IN_PROGRESS = 7;
	localparam int BIT_TERMINAL_MSG_IN_PROGRESS = 4;
	localparam int BIT_TERMINAL_BUS_INHIBITED = 2;
	localparam int BIT_EEPROM_CHECKSUM_ERROR = 1;
	localparam int BIT_RAM_INIT_FAIL = 0;
	// hardware pending interrupt bits raised alongside the error flags
	localparam int HW_PEND_CHECKSUM_BIT = 14;
	localparam int HW_PEND_RAM_INIT_BIT = 13;
	localparam int FLAG_WIDTH = 10;

	// events reported by the terminal engines
	typedef struct packed {
		logic bc_msg_start;
		logic bc_msg_done;
		logic bc_running;
		logic monitor_cmd_valid;
		logic monitor_msg_done;
		logic terminal_cmd_valid;
		logic terminal_msg_done;
		logic bus_shutdown_cmd;
		logic bus_shutdown_override_cmd;
		logic checksum_fail;
		logic ram_verify_fail;
	} status_events_t;
endpackage

// File: rtl/sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
// one status flag: set by an event, cleared by another, set wins
module sticky_flag
	import status_flags_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	// set has priority over a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1;
		else if (clear)
			flag <= 1'b0;
	end
endmodule
`default_nettype wire

// File: rtl/terminal_status_flags.sv
// Operation
// - bit 9 high until BC message fully completes
// - bit 8 high while BC enabled, running
// - bit 7 set on monitor command, cleared after
// - bit 4 set on terminal command, cleared after
// - bits 6, 5, 3 read zero
// - bit 2 high while shutdown inhibits bus
// - shutdown ends on override, reset, terminal soft reset
// - checksum failure sets bit 1, pending 14
// - RAM mismatch sets bit 0, pending 13
// - error flags need auto-init pin at reset
// - master reset clears; soft resets leave error flags
`timescale 1ns/1ps
`default_nettype none
module terminal_status_flags
	import status_flags_pkg::*;
#(
	parameter int SYNC_STAGES = 2
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic auto_init_enable_pin,
	input wire status_events_t events,
	input wire logic terminal_soft_reset_bit,
	input wire logic monitor_soft_reset_bit,
	output logic [15:0] master_status_low_flags,
	output logic [15:0] hw_pending_set
);
	// strap capture and soft reset edge
	logic [SYNC_STAGES-1:0] auto_sync;
	logic auto_init_armed;
	logic armed_taken;
	logic terminal_soft_q;
	logic terminal_soft_rise;
	// internal flags before the snapshot
	logic bc_msg_in_progress;
	logic bc_running;
	logic monitor_msg_in_progress;
	logic terminal_msg_in_progress;
	logic terminal_bus_inhibited;
	logic eeprom_checksum_error;
	logic ram_init_fail;
	// next values and strobes
	logic shutdown_clear;
	logic next_checksum;
	logic next_ram_fail;
	logic [15:0] next_status;
	logic [15:0] next_pending;

	// the strap must pass two flops before any logic reads it
	if (SYNC_STAGES < 2)
	begin : g_sync_check
		$error("terminal_status_flags: SYNC_STAGES below two");
	end

	// every flag must sit in the low flag field, pending bits in their word
	if (BIT_BC_MSG_IN_PROGRESS >= FLAG_WIDTH || BIT_BC_RUNNING >= FLAG_WIDTH
		|| BIT_MONITOR_MSG_IN_PROGRESS >= FLAG_WIDTH || BIT_TERMINAL_MSG_IN_PROGRESS >= FLAG_WIDTH
		|| BIT_TERMINAL_BUS_INHIBITED >= FLAG_WIDTH || BIT_EEPROM_CHECKSUM_ERROR >= FLAG_WIDTH
		|| BIT_RAM_INIT_FAIL >= FLAG_WIDTH || HW_PEND_CHECKSUM_BIT >= $bits(hw_pending_set)
		|| HW_PEND_RAM_INIT_BIT >= $bits(hw_pending_set))
	begin : g_field_check
		$error("terminal_status_flags: field position out of range");
	end

	// the two pending bits must not share a position
	if (HW_PEND_CHECKSUM_BIT == HW_PEND_RAM_INIT_BIT)
	begin : g_pend_check
		$error("terminal_status_flags: pending bits overlap");
	end

	// plain synchroniser, no reset: it keeps sampling while reset is held,
	// so its last stage carries the pin level from just before release
	always_ff @(posedge clk)
	begin
		auto_sync <= {auto_sync[SYNC_STAGES-2:0], auto_init_enable_pin};
	end

	// latch the strap once, at the first edge after master reset; error
	// events before that edge are not yet armed and are dropped
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			auto_init_armed <= 1'b0;
			armed_taken <= 1'b0;
		end
		else if (!armed_taken)
		begin
			auto_init_armed <= auto_sync[SYNC_STAGES-1];
			armed_taken <= 1'b1;
		end
	end

	// rising edge of the terminal soft reset bit
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			terminal_soft_q <= 1'b0;
		else
			terminal_soft_q <= terminal_soft_reset_bit;
	end

	// a soft reset ends a shutdown once, on the bit's rising edge; the edge
	// register resets low, the bit's idle level, so reset makes no false edge
	assign terminal_soft_rise = terminal_soft_reset_bit & ~terminal_soft_q;

	// override command or terminal soft reset lift the bus inhibit
	assign shutdown_clear = events.bus_shutdown_override_cmd | terminal_soft_rise;

	// controller message flag; a start and a done in one cycle leave it set
	sticky_flag u_bc_mip (
		.clk(clk),
		.reset_n(reset_n),
		.set(events.bc_msg_start),
		.clear(events.bc_msg_done),
		.flag(bc_msg_in_progress)
	);

	// monitor message flag, set on a decoded command
	sticky_flag u_mon_mip (
		.clk(clk),
		.reset_n(reset_n),
		.set(events.monitor_cmd_valid),
		.clear(events.monitor_msg_done),
		.flag(monitor_msg_in_progress)
	);

	// terminal message flag, set on a command for this terminal
	sticky_flag u_term_mip (
		.clk(clk),
		.reset_n(reset_n),
		.set(events.terminal_cmd_valid),
		.clear(events.terminal_msg_done),
		.flag(terminal_msg_in_progress)
	);

	// bus inhibit flag, set by shutdown, lifted by override or terminal soft reset
	sticky_flag u_inhibit (
		.clk(clk),
		.reset_n(reset_n),
		.set(events.bus_shutdown_cmd),
		.clear(shutdown_clear),
		.flag(terminal_bus_inhibited)
	);

	// running flag follows the controller, registered in this domain;
	// it is a level, so it needs no set and clear pairing
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			bc_running <= 1'b0;
		else
			bc_running <= events.bc_running;
	end

	// error events count only when the strap was high at master reset,
	// and only once the strap has been latched
	assign next_checksum = armed_taken & auto_init_armed & events.checksum_fail;
	assign next_ram_fail = armed_taken & auto_init_armed & events.ram_verify_fail;

	// checksum error flag, held until master reset; soft resets leave it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			eeprom_checksum_error <= 1'b0;
		else if (next_checksum)
			eeprom_checksum_error <= 1'b1;
	end

	// ram init fail flag, held until master reset; soft resets leave it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ram_init_fail <= 1'b0;
		else if (next_ram_fail)
			ram_init_fail <= 1'b1;
	end

	// pending interrupt set word: one-cycle pulses beside the error flags
	always_comb
	begin
		next_pending = MASTER_STATUS_RESET;
		next_pending[HW_PEND_CHECKSUM_BIT] = next_checksum;
		next_pending[HW_PEND_RAM_INIT_BIT] = next_ram_fail;
	end

	// registered so each pulse stands in the cycle its flag sets
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hw_pending_set <= MASTER_STATUS_RESET;
		else
			hw_pending_set <= next_pending;
	end

	// assemble the status word; reserved bits and bits 15 to 10 stay zero
	always_comb
	begin
		next_status = MASTER_STATUS_RESET;
		next_status[BIT_BC_MSG_IN_PROGRESS] = bc_msg_in_progress;
		next_status[BIT_BC_RUNNING] = bc_running;
		next_status[BIT_MONITOR_MSG_IN_PROGRESS] = monitor_msg_in_progress;
		next_status[BIT_TERMINAL_MSG_IN_PROGRESS] = terminal_msg_in_progress;
		next_status[BIT_TERMINAL_BUS_INHIBITED] = terminal_bus_inhibited;
		next_status[BIT_EEPROM_CHECKSUM_ERROR] = eeprom_checksum_error;
		next_status[BIT_RAM_INIT_FAIL] = ram_init_fail;
	end

	// snapshot the host serial port reads; every bit taken on one edge
	// keeps a read coherent while events arrive
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			master_status_low_flags <= MASTER_STATUS_RESET;
		else
			master_status_low_flags <= next_status;
	end

	// the monitor soft reset touches none of these flags
	logic unused_monitor_soft;
	assign unused_monitor_soft = monitor_soft_reset_bit;
endmodule
`default_nettype wire

// File: verification/event_source.sv
`timescale 1ns/1ps
`default_nettype none
// engine side: issues each requested event set on the falling edge
module event_source
	import status_flags_pkg::*;
(
	input wire logic clk,
	input wire status_events_t req,
	output status_events_t events
);
	initial events = '0;
	always @(negedge clk) events <= req;
endmodule
`default_nettype wire

// File: verification/tb_terminal_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_terminal_status_flags;
	import status_flags_pkg::*;
	logic clk = 0, reset_n = 0, pin = 0, trst = 0;
	status_events_t req = '0, ev, r;
	logic [15:0] flags, pend, want;
	logic [31:0] rnd = 32'h0001_17b5;
	int err_count = 0, n_checks = 0;
	initial forever #12.5 clk = ~clk;
	event_source src (.clk(clk), .req(req), .events(ev));
	terminal_status_flags uut (.clk(clk), .reset_n(reset_n), .auto_init_enable_pin(pin), .events(ev),
		.terminal_soft_reset_bit(trst), .monitor_soft_reset_bit(rnd[12]), .master_status_low_flags(flags),
		.hw_pending_set(pend));
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// status word after one set of events
	function automatic logic [15:0] predict(logic [15:0] s, status_events_t e, logic rise, logic a);
		s[9] = e.bc_msg_start | s[9] & ~e.bc_msg_done;
		s[7] = e.monitor_cmd_valid | s[7] & ~e.monitor_msg_done;
		s[4] = e.terminal_cmd_valid | s[4] & ~e.terminal_msg_done;
		s[2] = e.bus_shutdown_cmd | s[2] & ~e.bus_shutdown_override_cmd & ~rise;
		s[1] = s[1] | a & e.checksum_fail;
		s[0] = s[0] | a & e.ram_verify_fail;
		return s;
	endfunction
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// armed run, then a second reset with the strap low
	initial
	begin
		for (int p = 1; p >= 0; p--)
		begin
			pin = p[0];
			reset_n = 0;
			repeat (20) @(negedge clk);
			check("reset word", 16'h0000, flags);
			reset_n = 1;
			want = '0;
			for (int i = 0; i < 400; i++)
			begin
				rnd = lfsr(rnd);
				r = rnd[10:0];
				// corners: every set beside its clear, then both init errors alone
				if (i == 0)
					r = 11'h7ff;
				if (i == 1)
					r = 11'h003;
				@(negedge clk);
				req <= r;
				@(negedge clk);
				req <= status_events_t'(r & 11'h100);
				trst <= rnd[11];
				@(negedge clk);
				trst <= 0;
				check("pending", {1'b0, pin & r.checksum_fail, pin & r.ram_verify_fail, 13'h0000}, pend);
				@(negedge clk);
				want = predict(want, r, rnd[11], pin);
				want[8] = r.bc_running;
				check("status word", want, flags);
			end
		end
		summarize();
	end
endmodule
`default_nettype wire

// File: verification/terminal_status_flags_properties.sv
`timescale 1ns/1ps
`default_nettype none
// timing of the status word and pending pulses against their events
module status_flags_properties
	import status_flags_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire status_events_t events,
	input wire logic [15:0] master_status_low_flags,
	input wire logic [15:0] hw_pending_set
);
	wire logic [15:0] f = master_status_low_flags;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_bc_msg_set: assert property (events.bc_msg_start |-> ##2 f[9]) else $error("bit 9 not set");
	a_bc_msg_clear: assert property (events.bc_msg_done && !events.bc_msg_start |-> ##2 !f[9])
		else $error("bit 9 stuck");
	a_bc_run_follow: assert property (events.bc_running |-> ##2 f[8]) else $error("bit 8 low");
	a_monitor_set: assert property (events.monitor_cmd_valid |-> ##2 f[7]) else $error("bit 7 not set");
	a_terminal_clear: assert property (
		events.terminal_msg_done && !events.terminal_cmd_valid |-> ##2 !f[4]) else $error("bit 4 stuck");
	a_unused_zero: assert property ((f & 16'hfc68) == 0) else $error("unused bit set");
	a_shutdown_set: assert property (events.bus_shutdown_cmd |-> ##2 f[2]) else $error("bit 2 not set");
	a_shutdown_clear: assert property (
		events.bus_shutdown_override_cmd && !events.bus_shutdown_cmd |-> ##2 !f[2]) else $error("bit 2 stuck");
	a_checksum_pend: assert property ($rose(f[1]) |-> $past(hw_pending_set[14])) else $error("no pending 14");
	a_ram_pend: assert property ($rose(f[0]) |-> $past(hw_pending_set[13])) else $error("no pending 13");
endmodule
bind terminal_status_flags status_flags_properties u_props (.clk(clk), .reset_n(reset_n), .events(events),
	.master_status_low_flags(master_status_low_flags), .hw_pending_set(hw_pending_set));
`default_nettype wire
